//--- hw/fir_core.sv
// cascadable fir core: sample timing, delay line, result path, loader, ahb-lite registers
`timescale 1ns/1ps
`default_nettype none
module fir_core #(
    parameter int N_MAC = fir_pkg::NUM_MAC,
    parameter int TAPS = fir_pkg::MAX_TAPS
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // ahb-lite slave
    input wire fir_pkg::ahb_req_t ahb_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // sample and result buses
    input wire logic [fir_pkg::SAMPLE_W-1:0] network_a_sample_in_i,
    input wire logic [fir_pkg::SAMPLE_W-1:0] delayed_sample_bus_i,
    output logic [fir_pkg::SAMPLE_W-1:0] delayed_sample_bus_o,
    output logic delayed_sample_bus_oe_o,
    input wire logic [fir_pkg::ACC_W-1:0] expansion_result_bus_i,
    output logic [fir_pkg::ACC_W-1:0] expansion_result_bus_o,
    output logic expansion_result_bus_oe_o,
    output logic [fir_pkg::ACC_W-1:0] filter_result_bus_o,
    output logic filter_result_valid_o,
    // sample control
    input wire logic filter_enable_i,
    output logic delayed_filter_enable_o,
    input wire logic bank_select_i,
    input wire logic free_run_select_i,
    input wire logic accum_clear_n_i,
    output logic sample_clock_out_o,
    output logic busy_o,
    // stand-alone coefficient memory
    input wire logic mem_load_mode_i,
    input wire logic [fir_pkg::DEV_IDX_W-1:0] device_index_i,
    input wire logic [fir_pkg::COEF_IN_W-1:0] coef_input_bus_i,
    output logic [fir_pkg::MEM_ADDR_W-1:0] coef_mem_addr_o
);
    import fir_pkg::*;

    if (N_MAC != NUM_MAC || TAPS != N_MAC * MAX_PASSES) begin
        $error("fir_core: TAPS must be N_MAC times eight and N_MAC sixteen");
    end

    typedef enum logic {LD_IDLE, LD_RUN} ld_state_t;

    ////////////////////////////////////////////////////////////////////////
    // configuration and derived timing
    cfg_t cfg_q;
    logic dec;
    logic [1:0] wsh;
    logic [2:0] pmax;
    logic [2:0] wmax;
    logic [TAP_IDX_W-1:0] ntaps;
    logic [TAP_IDX_W-1:0] bbase;

    // decimation is not offered at 128 taps: the delay line cannot grow further
    assign dec = cfg_q.decim && (cfg_q.len_sel != 2'd3);
    assign wsh = cfg_q.len_sel + {1'b0, dec};
    assign pmax = 3'((4'd1 << cfg_q.len_sel) - 4'd1);
    assign wmax = 3'((4'd1 << wsh) - 4'd1);
    assign ntaps = TAP_IDX_W'(N_MAC << wsh);
    assign bbase = (ntaps >> 1) + TAP_IDX_W'(dec);

    ////////////////////////////////////////////////////////////////////////
    // busy, clear and sample timing
    logic init_q;
    logic [1:0] clr_cnt_q;
    logic clearing;
    ld_state_t ld_q;
    logic cap_q;
    logic busy;
    logic free_run_select_act;
    logic go;
    logic at_slot;
    logic take;
    logic running_q;
    logic [2:0] ph_q;
    logic half_q;
    logic [2:0] cyc;

    assign clearing = (clr_cnt_q != 2'd0);
    assign busy = init_q || clearing || (ld_q == LD_RUN) || cap_q;
    assign busy_o = busy;
    assign free_run_select_act = mem_load_mode_i && free_run_select_i;
    assign go = !busy && (filter_enable_i || free_run_select_act);
    assign at_slot = !running_q || (ph_q == pmax);
    assign take = at_slot && go;
    assign cyc = 3'(ph_q + (half_q ? pmax + 3'd1 : 3'd0));
    assign sample_clock_out_o = at_slot;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            init_q <= 1'b1;
        end else begin
            init_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            clr_cnt_q <= '0;
        end else if (!accum_clear_n_i) begin
            clr_cnt_q <= 2'(CLEAR_CYCLES);
        end else if (clearing) begin
            clr_cnt_q <= clr_cnt_q - 2'd1;
        end
    end

    // a clear drops the stream; the source re-synchronises with enable afterwards
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            running_q <= 1'b0;
            ph_q <= '0;
            half_q <= 1'b0;
        end else if (!accum_clear_n_i || clearing) begin
            running_q <= 1'b0;
            ph_q <= '0;
            half_q <= 1'b0;
        end else if (at_slot) begin
            running_q <= take;
            ph_q <= '0;
            half_q <= take && running_q && dec && !half_q;
        end else begin
            ph_q <= ph_q + 3'd1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // delay line, cascade sample and delayed enable
    logic [SAMPLE_W-1:0] dly_q [DLY_LEN];
    logic [SAMPLE_W-1:0] dout_q;
    logic [TAP_IDX_W-1:0] fill_q;
    logic delayed_filter_enable_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < DLY_LEN; i++) begin
                dly_q[i] <= '0;
            end
        end else if (take) begin
            for (int i = 0; i < DLY_LEN; i++) begin
                if (i == 0) begin
                    dly_q[i] <= network_a_sample_in_i;
                end else if (cfg_q.dual && TAP_IDX_W'(i) == bbase) begin
                    dly_q[i] <= delayed_sample_bus_i;
                end else begin
                    dly_q[i] <= dly_q[i-1];
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dout_q <= '0;
            fill_q <= '0;
            delayed_filter_enable_q <= 1'b0;
        end else if (take) begin
            dout_q <= dly_q[ntaps-TAP_IDX_W'(1)];
            fill_q <= !running_q ? TAP_IDX_W'(1) : (fill_q < ntaps ? fill_q + 8'h01 : fill_q);
            delayed_filter_enable_q <= running_q && (fill_q >= ntaps);
        end else if (at_slot) begin
            fill_q <= '0;
            delayed_filter_enable_q <= 1'b0;
        end
    end

    assign delayed_sample_bus_o = dout_q;
    assign delayed_sample_bus_oe_o = !cfg_q.dual;
    assign delayed_filter_enable_o = delayed_filter_enable_q;

    ////////////////////////////////////////////////////////////////////////
    // tap selection and the mac array
    logic [N_MAC-1:0][SAMPLE_W-1:0] mac_sample;
    logic [N_MAC-1:0][COEF_IDX_W-1:0] mac_cidx;
    logic [N_MAC-1:0][COEF_W-1:0] mac_coef;
    logic [N_MAC-1:0][ACC_W-1:0] acc;
    logic done_q;
    logic coef_we;
    logic coef_wbank;
    logic [COEF_IDX_W-1:0] coef_widx;
    logic [COEF_IN_W-1:0] coef_wdata;

    // mac m handles taps m*W .. m*W+W-1; the second half of a decimating window
    // sees the line shifted once more, and network b's region starts one later
    function automatic logic [TAP_IDX_W-1:0] tap_idx(input int m, input logic [1:0] sh,
                                                     input logic [2:0] c, input int extra);
        return TAP_IDX_W'((m << sh) + int'(c) + extra);
    endfunction

    always_comb begin
        for (int m = 0; m < N_MAC; m++) begin
            mac_cidx[m] = COEF_IDX_W'(tap_idx(m, wsh, cyc, 0));
            mac_sample[m] = dly_q[tap_idx(m, wsh, cyc, int'(half_q)
                + int'(cfg_q.dual && dec && m >= N_MAC / 2))];
        end
    end

    coef_store #(
        .DEPTH(TAPS),
        .PORTS(N_MAC),
        .IDX_W(COEF_IDX_W)
    ) u_coef (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .we_i(coef_we),
        .wbank_i(coef_wbank),
        .widx_i(coef_widx),
        .wdata_i(coef_wdata),
        .rbank_i(bank_select_i),
        .ridx_i(mac_cidx),
        .rdata_o(mac_coef)
    );

    mac_bank #(
        .N(N_MAC)
    ) u_mac (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .clr_i(clearing),
        .en_i(running_q && !clearing),
        .first_i(cyc == 3'd0),
        .sample_i(mac_sample),
        .coef_i(mac_coef),
        .acc_o(acc)
    );

    ////////////////////////////////////////////////////////////////////////
    // results
    logic [ACC_W-1:0] fres_q;
    logic [ACC_W-1:0] xres_q;
    logic valid_q;

    function automatic logic [ACC_W-1:0] half_sum(input logic [N_MAC-1:0][ACC_W-1:0] a,
                                                  input logic upper);
        logic [ACC_W-1:0] s;
        s = '0;
        for (int m = 0; m < N_MAC / 2; m++) begin
            s = s + a[m + (upper ? N_MAC / 2 : 0)];
        end
        return s;
    endfunction

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            done_q <= 1'b0;
        end else begin
            done_q <= running_q && !clearing && (cyc == wmax);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fres_q <= '0;
            xres_q <= '0;
            valid_q <= 1'b0;
        end else begin
            valid_q <= done_q;
            if (done_q && cfg_q.dual) begin
                fres_q <= half_sum(acc, 1'b0);
                xres_q <= half_sum(acc, 1'b1);
            end else if (done_q) begin
                fres_q <= half_sum(acc, 1'b0) + half_sum(acc, 1'b1)
                    + (cfg_q.exp_use ? expansion_result_bus_i : '0);
            end
        end
    end

    assign filter_result_bus_o = fres_q;
    assign filter_result_valid_o = valid_q;
    assign expansion_result_bus_o = xres_q;
    assign expansion_result_bus_oe_o = cfg_q.dual;

    ////////////////////////////////////////////////////////////////////////
    // ahb-lite slave: zero wait states, always okay
    logic ap;
    logic dp_wr_q;
    logic [7:0] dp_addr_q;
    logic [31:0] hrdata_q;
    logic [CADDR_W-1:0] caddr_q;
    logic host_we;
    logic load_req;
    logic [31:0] rd_mux;

    assign ap = ahb_i.hsel && ahb_i.htrans[1] && hready_i;
    assign host_we = dp_wr_q && (dp_addr_q == REG_COEF_DATA);
    assign load_req = dp_wr_q && (dp_addr_q == REG_CTRL) && ahb_i.hwdata[CTRL_LOAD_BIT];

    always_comb begin
        rd_mux = '0;
        case ({ahb_i.haddr[7:2], 2'b00})
            REG_CTRL: rd_mux[CFG_W-1:0] = cfg_q;
            REG_STATUS: begin
                rd_mux[STAT_BUSY_BIT] = busy;
                rd_mux[STAT_RUN_BIT] = running_q;
                rd_mux[STAT_LOAD_BIT] = (ld_q == LD_RUN);
            end
            REG_COEF_ADDR: rd_mux[CADDR_W-1:0] = caddr_q;
            default: rd_mux = '0;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dp_wr_q <= 1'b0;
            dp_addr_q <= '0;
            hrdata_q <= '0;
        end else begin
            dp_wr_q <= ap && ahb_i.hwrite;
            if (ap) begin
                dp_addr_q <= {ahb_i.haddr[7:2], 2'b00};
            end
            if (ap && !ahb_i.hwrite) begin
                hrdata_q <= rd_mux;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_q <= CFG_RESET;
            caddr_q <= '0;
        end else if (dp_wr_q) begin
            if (dp_addr_q == REG_CTRL) begin
                cfg_q <= cfg_t'(ahb_i.hwdata[CFG_W-1:0]);
            end else if (dp_addr_q == REG_COEF_ADDR) begin
                caddr_q <= ahb_i.hwdata[CADDR_W-1:0];
            end else if (host_we) begin
                caddr_q <= caddr_q + 8'h01;
            end
        end
    end

    assign hrdata_o = hrdata_q;
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // stand-alone byte memory loader, low byte first
    logic [LOAD_ADDR_W-1:0] ld_cnt_q;
    logic [LOAD_ADDR_W-1:0] cap_addr_q;
    logic [BYTE_W-1:0] lo_q;
    logic ld_we;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ld_q <= LD_IDLE;
            ld_cnt_q <= '0;
            cap_q <= 1'b0;
            cap_addr_q <= '0;
        end else begin
            cap_q <= (ld_q == LD_RUN);
            cap_addr_q <= ld_cnt_q;
            case (ld_q)
                LD_IDLE: begin
                    if (mem_load_mode_i && (init_q || load_req)) begin
                        ld_q <= LD_RUN;
                        ld_cnt_q <= '0;
                    end
                end
                LD_RUN: begin
                    ld_cnt_q <= ld_cnt_q + 9'h001;
                    if (ld_cnt_q == LOAD_LAST) begin
                        ld_q <= LD_IDLE;
                    end
                end
                default: ld_q <= LD_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lo_q <= '0;
        end else if (cap_q && !cap_addr_q[0]) begin
            lo_q <= coef_input_bus_i[BYTE_W-1:0];
        end
    end

    // the device index picks this device's slice of a shared memory
    assign coef_mem_addr_o = {device_index_i, ld_cnt_q};
    assign ld_we = cap_q && cap_addr_q[0];
    assign coef_we = ld_we || host_we;
    assign coef_wbank = ld_we ? cap_addr_q[LOAD_ADDR_W-1] : caddr_q[CADDR_BANK_BIT];
    assign coef_widx = ld_we ? cap_addr_q[LOAD_ADDR_W-2:1] : caddr_q[COEF_IDX_W-1:0];
    assign coef_wdata = ld_we ? {coef_input_bus_i[BYTE_W-1:0], lo_q}
                              : ahb_i.hwdata[COEF_IN_W-1:0];
endmodule
`default_nettype wire

//--- shared/fir_pkg.sv
// package: constants, register map and carrier types of the cascadable fir core
package fir_pkg;
    localparam int NUM_MAC = 16;
    localparam int MAX_TAPS = 128;
    localparam int MAX_PASSES = 8;
    localparam int SAMPLE_W = 16;
    localparam int COEF_IN_W = 16;
    localparam int COEF_W = 12;
    localparam int ACC_W = 32;
    localparam int DLY_LEN = MAX_TAPS + 2;
    localparam int TAP_IDX_W = 8;
    localparam int COEF_IDX_W = 7;
    localparam int DEV_IDX_W = 4;
    localparam int LOAD_ADDR_W = 9;
    localparam int MEM_ADDR_W = DEV_IDX_W + LOAD_ADDR_W;
    localparam int BYTE_W = 8;
    localparam int CLEAR_CYCLES = 2;
    localparam logic [LOAD_ADDR_W-1:0] LOAD_LAST = 9'h1ff;

    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_COEF_ADDR = 8'h08;
    localparam logic [7:0] REG_COEF_DATA = 8'h0c;

    // control fields, in the bit order of cfg_t
    localparam int CTRL_LEN_LSB = 0;
    localparam int CTRL_DUAL_BIT = 2;
    localparam int CTRL_DECIM_BIT = 3;
    localparam int CTRL_EXP_BIT = 4;
    localparam int CTRL_LOAD_BIT = 5;
    localparam int CFG_W = 5;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_RUN_BIT = 1;
    localparam int STAT_LOAD_BIT = 2;
    localparam int CADDR_W = 8;
    localparam int CADDR_BANK_BIT = 7;

    typedef struct packed {
        logic exp_use;
        logic decim;
        logic dual;
        logic [1:0] len_sel;
    } cfg_t;

    localparam cfg_t CFG_RESET = 5'h00;

    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
    } ahb_req_t;
endpackage

//--- hw/coef_store.sv
// two-bank coefficient storage with one write port and one read port per mac
`timescale 1ns/1ps
`default_nettype none
module coef_store #(
    parameter int DEPTH = 128,
    parameter int PORTS = 16,
    parameter int IDX_W = 7
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // write port, full-width coefficient
    input wire logic we_i,
    input wire logic wbank_i,
    input wire logic [IDX_W-1:0] widx_i,
    input wire logic [fir_pkg::COEF_IN_W-1:0] wdata_i,
    // read ports
    input wire logic rbank_i,
    input wire logic [PORTS-1:0][IDX_W-1:0] ridx_i,
    output logic [PORTS-1:0][fir_pkg::COEF_W-1:0] rdata_o
);
    import fir_pkg::*;

    if (DEPTH != (1 << IDX_W)) begin
        $error("coef_store: DEPTH must equal 2**IDX_W");
    end

    logic [COEF_W-1:0] mem_q [2][DEPTH];

    // keep the top bits: the sign and magnitude survive, fine lsbs are dropped
    function automatic logic [COEF_W-1:0] reduce_coef(input logic [COEF_IN_W-1:0] c);
        return c[COEF_IN_W-1 -: COEF_W];
    endfunction

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int b = 0; b < 2; b++) begin
                for (int i = 0; i < DEPTH; i++) begin
                    mem_q[b][i] <= '0;
                end
            end
        end else if (we_i) begin
            mem_q[wbank_i][widx_i] <= reduce_coef(wdata_i);
        end
    end

    always_comb begin
        for (int p = 0; p < PORTS; p++) begin
            rdata_o[p] = mem_q[rbank_i][ridx_i[p]];
        end
    end
endmodule
`default_nettype wire

//--- hw/mac_bank.sv
// bank of multiply-accumulators, one accumulator each
`timescale 1ns/1ps
`default_nettype none
module mac_bank #(
    parameter int N = 16
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // control
    input wire logic clr_i,
    input wire logic en_i,
    input wire logic first_i,
    // operands and sums
    input wire logic [N-1:0][fir_pkg::SAMPLE_W-1:0] sample_i,
    input wire logic [N-1:0][fir_pkg::COEF_W-1:0] coef_i,
    output logic [N-1:0][fir_pkg::ACC_W-1:0] acc_o
);
    import fir_pkg::*;

    if (N < 2) begin
        $error("mac_bank: N must be at least 2");
    end

    function automatic logic [ACC_W-1:0] product(input logic [SAMPLE_W-1:0] s,
                                                  input logic [COEF_W-1:0] c);
        logic signed [SAMPLE_W+COEF_W-1:0] p;
        p = $signed(s) * $signed(c);
        return ACC_W'(p);
    endfunction

    // no saturation: sums wrap, headroom is the coefficient designer's job
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_o <= '0;
        end else if (clr_i) begin
            acc_o <= '0;
        end else if (en_i) begin
            for (int m = 0; m < N; m++) begin
                acc_o[m] <= (first_i ? '0 : acc_o[m]) + product(sample_i[m], coef_i[m]);
            end
        end
    end
endmodule
`default_nettype wire

//--- dv/fir_core_properties.sv
// concurrent checks on the fir core ports
`timescale 1ns/1ps
`default_nettype none
module fir_core_checker (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // watched ports
    input wire logic filter_enable_i,
    input wire logic free_run_select_i,
    input wire logic mem_load_mode_i,
    input wire logic accum_clear_n_i,
    input wire logic busy_o,
    input wire logic sample_clock_out_o,
    input wire logic delayed_filter_enable_o,
    input wire logic [fir_pkg::SAMPLE_W-1:0] delayed_sample_bus_o,
    input wire logic delayed_sample_bus_oe_o,
    input wire logic expansion_result_bus_oe_o,
    input wire logic [fir_pkg::ACC_W-1:0] filter_result_bus_o,
    input wire logic filter_result_valid_o
);
    import fir_pkg::*;
    logic take;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    assign take = (filter_enable_i || (free_run_select_i && mem_load_mode_i))
        && sample_clock_out_o && !busy_o;
    ////////////////////////////////////////
    chk_clear_busy: assert property (!accum_clear_n_i |=> busy_o [*2])
        else $error("clear not covered by busy");
    chk_busy_holds: assert property (busy_o |=> $stable(delayed_sample_bus_o))
        else $error("sample taken while busy");
    chk_dly_on_take: assert property ($changed(delayed_sample_bus_o) |-> $past(take))
        else $error("delayed bus moved off a sample edge");
    chk_result_valid: assert property ($changed(filter_result_bus_o) |-> filter_result_valid_o)
        else $error("result changed without valid");
    chk_oe_split: assert property (delayed_sample_bus_oe_o != expansion_result_bus_oe_o)
        else $error("bus directions overlap");
    chk_den_rise: assert property ($rose(delayed_filter_enable_o) |-> $past(take))
        else $error("delayed enable rose off a sample edge");
    chk_first_take: assert property ($rose(filter_enable_i) && !busy_o |-> sample_clock_out_o)
        else $error("first enable edge not a sample slot");
    chk_load_busy: assert property (mem_load_mode_i && !$past(rst_n_i) |=> busy_o [*8])
        else $error("memory load did not hold busy");
    cover property (take ##1 take);
    cover property (!accum_clear_n_i);
    cover property ($fell(busy_o) && mem_load_mode_i);
endmodule
bind fir_core fir_core_checker u_fir_core_checker (.*);
`default_nettype wire

//--- dv/sample_source.sv
// upstream sample source and stand-alone coefficient byte memory
`timescale 1ns/1ps
`default_nettype none
module sample_source (
    // clock, reset and control
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic go_i,
    input wire logic free_i,
    // core status
    input wire logic sclk_i,
    input wire logic busy_i,
    input wire logic [fir_pkg::MEM_ADDR_W-1:0] mem_addr_i,
    // toward the core
    output logic [fir_pkg::SAMPLE_W-1:0] sample_o,
    output logic enable_o,
    output logic [fir_pkg::COEF_IN_W-1:0] coef_o
);
    import fir_pkg::*;
    int seed = 26092;
    function automatic logic [7:0] mem_byte(input logic [MEM_ADDR_W-1:0] a);
        return a[7:0] ^ {a[12:9], a[12:9]};
    endfunction
    ////////////////////////////////////////
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            enable_o <= 1'b0;
            sample_o <= 16'h0;
            coef_o <= 16'h0;
        end else begin
            // one cycle of memory latency; upper half is not ours, so it toggles
            coef_o <= {~mem_byte(mem_addr_i), mem_byte(mem_addr_i)};
            enable_o <= go_i && !free_i;
            if ((enable_o || free_i) && sclk_i && !busy_i) begin
                sample_o <= 16'($random(seed));
            end
        end
    end
endmodule
`default_nettype wire

//--- dv/tb_cascadable_fir_filter_core.sv
// self-checking bench: registers, host and memory loaded filtering
`timescale 1ns/1ps
`default_nettype none
module tb_cascadable_fir_filter_core;
    import fir_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    ahb_req_t ahb_q = '0;
    logic go_q = 1'b0, free_q = 1'b0, mem_q = 1'b0, bank_q = 1'b0, clr_n_q = 1'b1, rd_due = 1'b0;
    logic [3:0] dev_q = 4'h0;
    logic [15:0] dlyin_q = 16'h0, dly_o, sample, coef;
    logic [31:0] xin_q = 32'h0, hrdata, fres, xres, acc, accb;
    logic [12:0] maddr;
    logic hrdy, dly_oe, xoe, fval, en, sclk, busy, exp_use;
    logic dual_on = 1'b0;
    logic [11:0] cf [2][128];
    logic signed [15:0] hx [$], hy [$];
    logic [31:0] res_exp [$], rd_exp [$], xres_exp [$];
    int seed = 26092, taps = 16, cyc = 0, prev = -1, miscompares = 0, checks_done = 0;
    fir_core u_fir_core (.clk_i, .rst_n_i, .ahb_i(ahb_q), .hready_i(hrdy), .hrdata_o(hrdata),
        .hreadyout_o(hrdy), .hresp_o(), .network_a_sample_in_i(sample),
        .delayed_sample_bus_i(dlyin_q), .delayed_sample_bus_o(dly_o),
        .delayed_sample_bus_oe_o(dly_oe), .expansion_result_bus_i(xin_q),
        .expansion_result_bus_o(xres), .expansion_result_bus_oe_o(xoe),
        .filter_result_bus_o(fres), .filter_result_valid_o(fval), .filter_enable_i(en),
        .delayed_filter_enable_o(),
        .bank_select_i(bank_q), .free_run_select_i(free_q), .accum_clear_n_i(clr_n_q),
        .sample_clock_out_o(sclk), .busy_o(busy), .mem_load_mode_i(mem_q),
        .device_index_i(dev_q), .coef_input_bus_i(coef), .coef_mem_addr_o(maddr));
    sample_source u_sample_source (.clk_i, .rst_n_i, .go_i(go_q), .free_i(free_q && mem_q),
        .sclk_i(sclk), .busy_i(busy), .mem_addr_i(maddr), .sample_o(sample), .enable_o(en),
        .coef_o(coef));
    always #2.5 clk_i = ~clk_i;
    ////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // read data is compared by the monitor at the data-phase edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        ahb_q <= '{1'b1, {24'h0, a}, 2'h2, wr, 3'h2, ahb_q.hwdata};
        do @(posedge clk_i); while (hrdy !== 1'b1);
        ahb_q <= '{1'b0, ahb_q.haddr, 2'h0, wr, 3'h2, d};
        rd_due <= !wr;
        if (!wr) rd_exp.push_back(d);
        do @(posedge clk_i); while (hrdy !== 1'b1);
        rd_due <= 1'b0;
    endtask
    task automatic reset_dut(input logic mem);
        rst_n_i <= 1'b0;
        mem_q <= mem;
        hx.delete();
        hy.delete();
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
    endtask
    task automatic load_coefs();
        logic [15:0] c;
        bus(1'b1, REG_COEF_ADDR, 32'h0);
        for (int i = 0; i < taps; i++) begin
            c = 16'($random(seed));
            cf[0][i] = c[15:4];
            bus(1'b1, REG_COEF_DATA, {16'h0, c});
        end
    endtask
    task automatic stream(input int n);
        go_q <= 1'b1;
        repeat (n) @(posedge clk_i);
        go_q <= 1'b0;
        repeat (40) @(posedge clk_i);
        check(32'(res_exp.size()), 32'h0);
        check(32'(xres_exp.size()), 32'h0);
    endtask
    function automatic logic [7:0] mb(input int i, input logic hi);
        return u_sample_source.mem_byte({dev_q, 8'(i), hi});
    endfunction
    ////////////////////////////////////////
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 30000) begin
            miscompares++;
            end_of_test();
        end
        if (rd_due) check(hrdata, rd_exp.pop_front());
        if (fval === 1'b1) check(fres, res_exp.pop_front());
        if (fval === 1'b1 && dual_on) check(xres, xres_exp.pop_front());
        if (rst_n_i && (en || (free_q && mem_q)) && sclk && !busy) begin
            if (prev >= 0) check(32'(cyc - prev), 32'(taps / 16));
            if (!dual_on) begin
                check({16'h0, dly_o}, {16'h0, hx.size() > taps ? hx[taps] : 16'h0});
            end
            prev = cyc;
            hx.push_front(sample);
            hy.push_front(dlyin_q);
            dlyin_q <= 16'($random(seed));
            acc = exp_use && !dual_on ? xin_q : 32'h0;
            accb = 32'h0;
            for (int t = 0; t < (dual_on ? taps / 2 : taps) && t < hx.size(); t++) begin
                acc += 32'(hx[t] * $signed(cf[bank_q][t]));
                if (dual_on) accb += 32'(hy[t] * $signed(cf[bank_q][t + taps / 2]));
            end
            res_exp.push_back(acc);
            if (dual_on) xres_exp.push_back(accb);
        end else if (!en && !free_q) prev = -1;
    end
    initial begin
        reset_dut(1'b0);
        bus(1'b0, REG_STATUS, 32'h0);
        bus(1'b1, 8'h10, 32'hffffffff);
        bus(1'b0, 8'h10, 32'h0);
        bus(1'b1, REG_CTRL, 32'h3f);
        bus(1'b0, REG_CTRL, 32'h1f);
        check({30'h0, dly_oe, xoe}, 32'h1);
        for (int len = 0; len < 4; len++) begin
            reset_dut(1'b0);
            taps = 16 << len;
            exp_use = 1'b1;
            dual_on = (len == 1);
            xin_q <= 32'($random(seed));
            load_coefs();
            bus(1'b1, REG_CTRL, 32'h10 | len | (dual_on ? 32'h4 : 32'h0));
            stream(20 << (2 * len));
            clr_n_q <= 1'b0;
            @(posedge clk_i);
            clr_n_q <= 1'b1;
            repeat (4) @(posedge clk_i);
        end
        dev_q <= 4'h9;
        bank_q <= 1'b1;
        exp_use = 1'b0;
        dual_on = 1'b0;
        taps = 16;
        reset_dut(1'b1);
        for (int i = 0; i < 256; i++) cf[i / 128][i % 128] = 12'({mb(i, 1'b1), mb(i, 1'b0)} >> 4);
        do @(posedge clk_i); while (busy !== 1'b0);
        bus(1'b1, REG_CTRL, 32'h20);
        bus(1'b0, REG_STATUS, 32'h5);
        do @(posedge clk_i); while (busy !== 1'b0);
        free_q <= 1'b1;
        repeat (30) @(posedge clk_i);
        free_q <= 1'b0;
        repeat (40) @(posedge clk_i);
        check(32'(res_exp.size()), 32'h0);
        end_of_test();
    end
endmodule
`default_nettype wire
